//--- common/pxs_map.svh
// Purpose: Offsets, field positions, reset values and codes of the capability word
// Assumes: Included by bare name; one aligned 32-bit word per register
// Notes:   Event register layout mirrors status bits 21:18
// Behaviour
// - Capability identifier byte reads fixed 07h
// - Next-capability pointer reads fixed 90h
// - Bit 16 reads zero: no 64-bit
// - Bit 17 shows 133MHz ability, mode dependent
// - Set bit 18 on dropped split completion
// - Bit 18 zero in reverse, clearable forward
// - Set bit 19 on unmatched own-ID completion
// - Bit 19 forced zero in forward mode
// - Set bit 20 on buffer-full completion cut
// - Set bit 21 when split request delayed
// - Bits 24:22 encode secondary clock class
// - Clock class reads zero in reverse mode
`ifndef PXS_MAP_SVH
`define PXS_MAP_SVH
`define PXS_OFS_CAP      8'h80
`define PXS_OFS_CTRL     8'h88
`define PXS_OFS_IMASK    8'h8c
`define PXS_CAP_ID       8'h07
`define PXS_NEXT_PTR     8'h90
`define PXS_BIT_64       16
`define PXS_BIT_133      17
`define PXS_BIT_DISC     18
`define PXS_BIT_UNEXP    19
`define PXS_BIT_OVRUN    20
`define PXS_BIT_DELAY    21
`define PXS_CLK_LSB      22
`define PXS_CLK_CONV     3'h0
`define PXS_CLK_66       3'h1
`define PXS_CLK_133      3'h2
`define PXS_CTRL_REV     0
`define PXS_CTRL_C133    1
`define PXS_CTRL_CLK_LSB 4
`define PXS_CTRL_RST     32'h0000_0002
`endif

//--- common/pxs_pkg.sv
// Purpose: Types of the capability/status register group
// Assumes: Constants live in pxs_map.svh
// Notes:   Flags held as a 4-bit vector, bit 0 = discarded completion
package pxs_pkg;
  typedef struct packed {
    logic       disc;
    logic       unexp;
    logic       ovrun;
    logic       delay;
  } pxs_evt_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } pxs_ahb_req_t;

  typedef struct packed {
    logic        dph_act;
    logic        dph_wr;
    logic [7:0]  dph_addr;
    logic        hready;
    logic [31:0] hrdata;
    logic [3:0]  flags;
    logic [3:0]  imask;
    logic        rev_mode;
    logic        cap133;
    logic [2:0]  clk_class;
    logic        irq;
  } pxs_state_t;
endpackage

//--- design/pxs_regs.sv
// Purpose: Capability word at 80h with secondary status, AHB-Lite slave
// Assumes: Single word transfers; zero-wait slave; OKAY always
// Notes:   Mode and clock class come from a control register at 88h
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pxs_map.svh"
module pxs_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire pxs_pkg::pxs_evt_t    evt,
  output logic                      irq,
  output logic                      rev_mode
);
  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) $error("ADDR_W must be 8..32");
  end

  pxs_pkg::pxs_state_t st_r;
  pxs_pkg::pxs_state_t st_nxt;
  logic [3:0] set_v;
  logic [3:0] clr_v;
  logic [31:0] cap_word;

  // Addressed word match used for reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  // Assemble the capability and secondary status word
  always_comb begin
    cap_word = 32'h0;
    cap_word[7:0]  = `PXS_CAP_ID;
    cap_word[15:8] = `PXS_NEXT_PTR;
    cap_word[`PXS_BIT_64] = 1'b0;
    cap_word[`PXS_BIT_133] = st_r.cap133 & ~st_r.rev_mode;
    cap_word[`PXS_BIT_DELAY:`PXS_BIT_DISC] = st_r.flags;
    cap_word[`PXS_CLK_LSB+2:`PXS_CLK_LSB] =
      st_r.rev_mode ? 3'h0 : st_r.clk_class;
  end

  // Event sets, discard and unexpected filtered by bridge mode; write-one clears from the capability word
  always_comb begin
    set_v = 4'h0;
    set_v[0] = evt.disc & ~st_r.rev_mode;
    set_v[1] = evt.unexp & st_r.rev_mode;
    set_v[2] = evt.ovrun;
    set_v[3] = evt.delay;
    clr_v = 4'h0;
    if (st_r.dph_act && st_r.dph_wr && hit(st_r.dph_addr, `PXS_OFS_CAP)) begin
      clr_v = hwdata[`PXS_BIT_DELAY:`PXS_BIT_DISC];
    end
  end

  // Next state: bus phases, registers, flags
  always_comb begin
    st_nxt = st_r;
    st_nxt.hready = 1'b1;
    // Flags: set wins over clear, mode gates hold bits at zero
    st_nxt.flags = (st_r.flags & ~clr_v) | set_v;
    if (st_r.rev_mode) begin
      st_nxt.flags[0] = 1'b0;
    end else begin
      st_nxt.flags[1] = 1'b0;
    end
    if (st_r.dph_act && st_r.dph_wr) begin
      if (hit(st_r.dph_addr, `PXS_OFS_CTRL)) begin
        st_nxt.rev_mode  = hwdata[`PXS_CTRL_REV];
        st_nxt.cap133    = hwdata[`PXS_CTRL_C133];
        st_nxt.clk_class = hwdata[`PXS_CTRL_CLK_LSB+2:`PXS_CTRL_CLK_LSB];
      end
      if (hit(st_r.dph_addr, `PXS_OFS_IMASK)) begin
        st_nxt.imask = hwdata[3:0]; // Mask word keeps flags at bits 3:0
      end
    end
    // Address phase capture
    st_nxt.dph_act  = hsel && hready && htrans[1];
    st_nxt.dph_wr   = hwrite;
    st_nxt.dph_addr = haddr[7:0];
    st_nxt.hrdata   = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (hit(haddr[7:0], `PXS_OFS_CAP)) begin
        st_nxt.hrdata = cap_word;
        st_nxt.hrdata[`PXS_BIT_DELAY:`PXS_BIT_DISC] = st_nxt.flags;
      end else if (hit(haddr[7:0], `PXS_OFS_CTRL)) begin
        st_nxt.hrdata = {25'h0, st_r.clk_class, 2'h0, st_r.cap133, st_r.rev_mode};
      end else if (hit(haddr[7:0], `PXS_OFS_IMASK)) begin
        st_nxt.hrdata = {28'h0, st_r.imask};
      end
    end
    st_nxt.irq = |(st_nxt.flags & st_nxt.imask);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.hready <= 1'b1;
      st_r.cap133 <= 1'b1; // Clock class field comes out of reset as 000
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.hready;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.hrdata;
  assign irq       = st_r.irq;
  assign rev_mode  = st_r.rev_mode;

  // Checks
  a_disc_rev_zero: assert property (@(posedge ref_clk) disable iff (reset)
    st_r.rev_mode |=> !st_r.flags[0] || $past(!st_r.rev_mode))
    else $error("discarded flag set in reverse mode");
  a_unexp_fwd_zero: assert property (@(posedge ref_clk) disable iff (reset)
    !st_r.rev_mode && !$past(st_r.rev_mode) |-> !st_r.flags[1])
    else $error("unexpected flag set in forward mode");
  a_ovrun_sets: assert property (@(posedge ref_clk) disable iff (reset)
    evt.ovrun |=> st_r.flags[2])
    else $error("overrun flag not set");
  a_delay_sets: assert property (@(posedge ref_clk) disable iff (reset)
    evt.delay |=> st_r.flags[3])
    else $error("delay flag not set");
  a_disc_sets: assert property (@(posedge ref_clk) disable iff (reset)
    evt.disc && !st_r.rev_mode |=> st_r.flags[0] || st_r.rev_mode)
    else $error("discard flag not set");
  a_unexp_sets: assert property (@(posedge ref_clk) disable iff (reset)
    evt.unexp && st_r.rev_mode |=> st_r.flags[1] || !st_r.rev_mode)
    else $error("unexpected flag not set");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    st_r.flags[2] && !(clr_v[2]) |=> st_r.flags[2])
    else $error("overrun flag lost without clear");
  a_cap_const: assert property (@(posedge ref_clk) disable iff (reset)
    cap_word[15:0] == 16'h9007 && !cap_word[16])
    else $error("capability header wrong");
  a_clk_rev_zero: assert property (@(posedge ref_clk) disable iff (reset)
    st_r.rev_mode |-> cap_word[24:22] == 3'h0 && !cap_word[17])
    else $error("clock class or 133 bit set in reverse");

  // Read address phase aimed at the capability word
  sequence s_cap_read;
    hsel && hready && htrans[1] && !hwrite && haddr[7:2] == 6'h20;
  endsequence
  a_cap_read_data: assert property (@(posedge ref_clk) disable iff (reset)
    s_cap_read |=> hrdata[15:0] == 16'h9007 && !hrdata[16])
    else $error("capability read data wrong");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
    irq == |(st_r.flags & st_r.imask))
    else $error("interrupt level differs from masked flags");
  a_bus_okay: assert property (@(posedge ref_clk) disable iff (reset)
    hreadyout && !hresp)
    else $error("slave not ready or not okay");
endmodule

//--- tb/pxs_sec_agent.sv
// Purpose: Secondary-bus agent that reports split-transaction events
// Assumes: Bench names the events to raise, one cycle at a time
// Notes:   Each event leaves as a one-cycle high pulse
`timescale 1ns/1ps
module pxs_sec_agent (
  input  wire logic              ref_clk,
  input  wire pxs_pkg::pxs_evt_t cmd,
  output pxs_pkg::pxs_evt_t      evt
);
  // Drop, unmatched completion, overrun cut and delayed request
  always @(posedge ref_clk) begin
    evt <= cmd;
  end
endmodule

//--- tb/test_pxs_regs.sv
// Purpose: Register-level test of the capability and status word
// Assumes: Zero-wait slave; hready looped back from hreadyout
// Notes:   Read data captured at the falling edge in the middle of the data phase
`timescale 1ns/1ps
`include "pxs_map.svh"
module test_pxs_regs;
  logic              ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, hreadyout;
  logic              hresp, irq, rev_mode;
  logic [1:0]        htrans = 2'h0;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata;
  pxs_pkg::pxs_evt_t cmd = 4'h0, evt;
  int                n_errors = 0, total_checks = 0, cyc = 0;
  pxs_regs dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .irq(irq),
    .rev_mode(rev_mode));
  pxs_sec_agent agent_u (.ref_clk(ref_clk), .cmd(cmd), .evt(evt));
  // Clock, cycle count and hang guard
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end
  task give_verdict();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer, entered just after a rising edge; settled values read at mid-cycle
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    logic rdy;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(negedge ref_clk);
      rdy = hreadyout;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge ref_clk);
      rdy = hreadyout;
      q = hrdata;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  // Pulse events at the far side and let them land
  task fire(input logic [3:0] v);
    cmd <= v;
    @(posedge ref_clk);
    cmd <= 4'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  // Look at a pin where it is settled, then return to the rising edge
  task pin(input logic [31:0] exp);
    @(negedge ref_clk);
    chk({31'h0, irq}, exp);
    @(posedge ref_clk);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(`PXS_OFS_CAP, 32'h0002_9007);
    rd(8'h90, 32'h0);
    rd(`PXS_OFS_CTRL, `PXS_CTRL_RST);
    fire(4'hf);
    rd(`PXS_OFS_CAP, 32'h0036_9007);
    pin(32'h0);
    wr(`PXS_OFS_IMASK, 32'hf);
    rd(`PXS_OFS_IMASK, 32'hf);
    pin(32'h1);
    wr(`PXS_OFS_CAP, 32'h0);
    rd(`PXS_OFS_CAP, 32'h0036_9007);
    wr(`PXS_OFS_CAP, 32'h003c_0000);
    rd(`PXS_OFS_CAP, 32'h0002_9007);
    pin(32'h0);
    wr(`PXS_OFS_CTRL, 32'h23);
    @(negedge ref_clk);
    chk({31'h0, rev_mode}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    @(posedge ref_clk);
    rd(`PXS_OFS_CAP, 32'h0000_9007);
    fire(4'hf);
    rd(`PXS_OFS_CAP, 32'h0038_9007);
    wr(`PXS_OFS_CAP, 32'h003c_0000);
    rd(`PXS_OFS_CAP, 32'h0000_9007);
    wr(`PXS_OFS_CTRL, 32'h10);
    rd(`PXS_OFS_CAP, 32'h0040_9007);
    give_verdict();
  end
endmodule
